// ==== verilog/mft_pkg.sv ====
package mft_pkg;

  // ----------------------------------------------------------------
  // channel counts and counter values
  // ----------------------------------------------------------------
  localparam int NA = 2;
  localparam int NB = 3;
  localparam logic [15:0] CNT_RST = 16'h0000;
  localparam logic [15:0] CNT_ONE = 16'h0001;
  localparam logic [15:0] PER16_M1 = 16'hFFFE;
  localparam logic [15:0] PER8_M1 = 16'h00FE;
  localparam logic [7:0] PRE_ZERO = 8'h00;
  localparam logic [7:0] PRE_ONE = 8'h01;
  // value returned for a modulator channel read; it is arbitrary
  localparam logic [15:0] PWM_RD_VAL = 16'h0000;

  // ----------------------------------------------------------------
  // selector codes
  // ----------------------------------------------------------------
  localparam logic [1:0] SRC_DIV1 = 2'h0;
  localparam logic [1:0] SRC_DIV8 = 2'h1;
  localparam logic [1:0] SRC_DIV32 = 2'h2;
  localparam logic [1:0] SRC_SUB32 = 2'h3;
  localparam logic [1:0] TB_TIMER = 2'h0;
  localparam logic [1:0] TB_EVENT = 2'h1;
  localparam logic [1:0] TB_MEAS = 2'h2;
  localparam logic [1:0] EDGE_FALL = 2'h0;
  localparam logic [1:0] EDGE_RISE = 2'h1;
  localparam logic [1:0] EDGE_BOTH = 2'h2;
  localparam logic [2:0] DIV8_LAST = 3'h7;
  localparam logic [4:0] DIV32_LAST = 5'h1F;
  localparam logic [4:0] DIV_ONE = 5'h01;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic {ST_STOP = 1'b0, ST_RUN = 1'b1} mft_state_t;

  typedef struct packed {
    logic div1;
    logic div8;
    logic div32;
    logic sub32;
  } mft_ticks_t;

  typedef struct packed {
    logic [1:0] src;
    logic mode8;
    logic trig_en;
  } mft_pwm_cfg_t;

  typedef struct packed {
    logic [1:0] mode;
    logic [1:0] src;
    logic [1:0] edge_sel;
    logic ev_neigh;
  } mft_tb_cfg_t;

  function automatic logic pick_tick(input mft_ticks_t t, input logic [1:0] s);
    case (s)
      SRC_DIV1: pick_tick = t.div1;
      SRC_DIV8: pick_tick = t.div8;
      SRC_DIV32: pick_tick = t.div32;
      SRC_SUB32: pick_tick = t.sub32;
      default: pick_tick = 1'b0;
    endcase
  endfunction

endpackage

// ==== verilog/mft_sync.sv ====
`timescale 1ns/10ps
`default_nettype none
module mft_sync #(
  parameter int W = 1
) (
  input wire logic clock,
  input wire logic nrst,
  input wire logic [W-1:0] pin,
  output logic [W-1:0] level,
  output logic [W-1:0] rise,
  output logic [W-1:0] fall
);
  import mft_pkg::*;

  logic [W-1:0] s1_q, s2_q, s3_q;

  always_ff @(posedge clock) begin
    if (!nrst) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
    end else begin
      s1_q <= pin;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // only the second and third stages feed logic
  assign level = s2_q;
  assign rise = s2_q & ~s3_q;
  assign fall = ~s2_q & s3_q;

endmodule
`default_nettype wire

// ==== verilog/mft_prescaler.sv ====
`timescale 1ns/10ps
`default_nettype none
module mft_prescaler (
  input wire logic clock,
  input wire logic nrst,
  input wire logic sub_rise,
  output mft_pkg::mft_ticks_t ticks
);
  import mft_pkg::*;

  logic [4:0] div_q, div_d, sub_q, sub_d;
  mft_ticks_t tk_q, tk_d;

  always_comb begin
    div_d = div_q + DIV_ONE;
    sub_d = sub_rise ? sub_q + DIV_ONE : sub_q;
    tk_d.div1 = 1'b1;
    tk_d.div8 = (div_q[2:0] == DIV8_LAST);
    tk_d.div32 = (div_q == DIV32_LAST);
    tk_d.sub32 = sub_rise && (sub_q == DIV32_LAST);
  end

  always_ff @(posedge clock) begin
    if (!nrst) begin
      div_q <= 5'h00;
      sub_q <= 5'h00;
      tk_q <= '0;
    end else begin
      div_q <= div_d;
      sub_q <= sub_d;
      tk_q <= tk_d;
    end
  end

  assign ticks = tk_q;

endmodule
`default_nettype wire

// ==== verilog/mft_top.sv ====
`timescale 1ns/10ps
`default_nettype none
// Notes on behaviour
// - modulator counts down on selected prescaled clock
// - modulator reloads at rising output edge
// - triggers ignored while modulator counts
// - 16-bit: high n, period 65535
// - 8-bit: high n times (m+1)
// - 8-bit: period 255 times (m+1)
// - start on flag, also needing a trigger when trig_en is set, stop on clear
// - modulator interrupt on output falling while running; a stop raises none
// - modulators only on channels two, three
// - modulator read returns fixed meaningless value
// - stopped write loads counter, else reload
// - counter b mode from two bits
// - timer mode counts clock, pin stays port
// - underflow reloads, continues, raises interrupt
// - underflow rate source over n plus one
// - counter b runs while start flag set, in timer or event mode only
// - event mode counts pin or neighbour underflow
// - pin edge polarity selectable rise fall both
// - counter b read gives live count
// - counter b stopped write loads both
module mft_top (
  input wire logic clock,
  input wire logic nrst,
  input wire logic subclk_pin,
  input wire logic [15:0] wdata,
  input wire logic [mft_pkg::NA-1:0] start_a,
  input wire logic [mft_pkg::NA-1:0] trig_a,
  input wire logic [mft_pkg::NA-1:0] wr_a,
  input wire mft_pkg::mft_pwm_cfg_t [mft_pkg::NA-1:0] pwm_cfg,
  input wire logic [mft_pkg::NB-1:0] start_b,
  input wire logic [mft_pkg::NB-1:0] wr_b,
  input wire mft_pkg::mft_tb_cfg_t [mft_pkg::NB-1:0] tb_cfg,
  input wire logic [mft_pkg::NB-1:0] counter_b_input_pin,
  output logic pwm_ch2_output_pin,
  output logic pwm_ch3_output_pin,
  output logic [mft_pkg::NA-1:0] irq_a,
  output logic [mft_pkg::NA-1:0][15:0] pwm_rdata,
  output logic [mft_pkg::NB-1:0] irq_b,
  output logic [mft_pkg::NB-1:0][15:0] tb_count,
  output logic [mft_pkg::NB-1:0] counter_b_pin_level
);
  import mft_pkg::*;

  // ----------------------------------------------------------------
  // clock sources and pin synchronisers
  // ----------------------------------------------------------------
  mft_ticks_t ticks;
  logic sub_rise;
  logic [NB-1:0] pin_rise, pin_fall;

  mft_sync #(
    .W(1)
  ) u_sub_sync (
    .clock(clock),
    .nrst(nrst),
    .pin(subclk_pin),
    .level(),
    .rise(sub_rise),
    .fall()
  );

  mft_sync #(
    .W(NB)
  ) u_pin_sync (
    .clock(clock),
    .nrst(nrst),
    .pin(counter_b_input_pin),
    .level(counter_b_pin_level),
    .rise(pin_rise),
    .fall(pin_fall)
  );

  mft_prescaler u_presc (
    .clock(clock),
    .nrst(nrst),
    .sub_rise(sub_rise),
    .ticks(ticks)
  );

  // ----------------------------------------------------------------
  // modulator channel state
  // ----------------------------------------------------------------
  mft_state_t [NA-1:0] a_st_q, a_st_d;
  logic [NA-1:0][15:0] a_rel_q, a_rel_d;
  logic [NA-1:0][15:0] a_cur_q, a_cur_d;
  logic [NA-1:0][15:0] a_cnt_q, a_cnt_d;
  logic [NA-1:0][7:0] a_pre_q, a_pre_d;
  logic [NA-1:0] a_out_q, a_out_d;
  logic [NA-1:0] a_irq_q, a_irq_d;
  logic [NA-1:0][15:0] a_per, a_el, a_n;
  logic [NA-1:0] a_tick;

  // ----------------------------------------------------------------
  // modulator next state
  // ----------------------------------------------------------------
  // cnt walks the period down to zero; the output is high while the
  // steps already taken are fewer than n, so high time and period
  // come from one counter and cannot drift apart.
  always_comb begin
    for (int i = 0; i < NA; i++) begin
      a_per[i] = pwm_cfg[i].mode8 ? PER8_M1 : PER16_M1;
      a_tick[i] = pick_tick(ticks, pwm_cfg[i].src);
      a_st_d[i] = a_st_q[i];
      a_rel_d[i] = a_rel_q[i];
      a_cur_d[i] = a_cur_q[i];
      a_cnt_d[i] = a_cnt_q[i];
      a_pre_d[i] = a_pre_q[i];
      if (wr_a[i]) begin
        a_rel_d[i] = wdata;
        if (a_st_q[i] == ST_STOP) begin
          a_cur_d[i] = wdata;
        end
      end
      case (a_st_q[i])
        ST_STOP: begin
          if (start_a[i] && (!pwm_cfg[i].trig_en || trig_a[i])) begin
            a_st_d[i] = ST_RUN;
            a_cnt_d[i] = a_per[i];
            a_pre_d[i] = a_cur_d[i][7:0];
          end
        end
        ST_RUN: begin
          // trig_a is not looked at here at all
          if (!start_a[i]) begin
            a_st_d[i] = ST_STOP;
          end else if (a_tick[i]) begin
            if (pwm_cfg[i].mode8 && (a_pre_q[i] != PRE_ZERO)) begin
              a_pre_d[i] = a_pre_q[i] - PRE_ONE;
            end else if (a_cnt_q[i] == CNT_RST) begin
              a_cur_d[i] = a_rel_q[i];
              a_cnt_d[i] = a_per[i];
              a_pre_d[i] = a_rel_q[i][7:0];
            end else begin
              a_cnt_d[i] = a_cnt_q[i] - CNT_ONE;
              a_pre_d[i] = a_cur_q[i][7:0];
            end
          end
        end
        default: begin
          a_st_d[i] = ST_STOP;
        end
      endcase
      a_el[i] = a_per[i] - a_cnt_d[i];
      a_n[i] = pwm_cfg[i].mode8 ? {8'h00, a_cur_d[i][15:8]} : a_cur_d[i];
      a_out_d[i] = (a_st_d[i] == ST_RUN) && (a_el[i] < a_n[i]);
      // a stop is not a pulse end, so it raises no request
      a_irq_d[i] = a_out_q[i] && !a_out_d[i] && (a_st_d[i] == ST_RUN);
    end
  end

  always_ff @(posedge clock) begin
    if (!nrst) begin
      for (int i = 0; i < NA; i++) begin
        a_st_q[i] <= ST_STOP;
        a_rel_q[i] <= CNT_RST;
        a_cur_q[i] <= CNT_RST;
        a_cnt_q[i] <= CNT_RST;
        a_pre_q[i] <= PRE_ZERO;
      end
      a_out_q <= '0;
      a_irq_q <= '0;
    end else begin
      a_st_q <= a_st_d;
      a_rel_q <= a_rel_d;
      a_cur_q <= a_cur_d;
      a_cnt_q <= a_cnt_d;
      a_pre_q <= a_pre_d;
      a_out_q <= a_out_d;
      a_irq_q <= a_irq_d;
    end
  end

  // ----------------------------------------------------------------
  // counter b channel state
  // ----------------------------------------------------------------
  mft_state_t [NB-1:0] b_st_q, b_st_d;
  logic [NB-1:0][15:0] b_rel_q, b_rel_d;
  logic [NB-1:0][15:0] b_cnt_q, b_cnt_d;
  logic [NB-1:0] b_uf_q, b_uf_d;
  logic [NB-1:0] b_pin_ev, b_ev, b_counting;

  // ----------------------------------------------------------------
  // counter b next state
  // ----------------------------------------------------------------
  // the neighbour of channel i is channel i-1 (0 takes the last one);
  // its underflow is seen one cycle late, which keeps the chain free
  // of combinational loops.
  always_comb begin
    for (int i = 0; i < NB; i++) begin
      b_counting[i] = (tb_cfg[i].mode == TB_TIMER) || (tb_cfg[i].mode == TB_EVENT);
      case (tb_cfg[i].edge_sel)
        EDGE_FALL: b_pin_ev[i] = pin_fall[i];
        EDGE_RISE: b_pin_ev[i] = pin_rise[i];
        EDGE_BOTH: b_pin_ev[i] = pin_rise[i] | pin_fall[i];
        default: b_pin_ev[i] = 1'b0;
      endcase
      case (tb_cfg[i].mode)
        TB_TIMER: b_ev[i] = pick_tick(ticks, tb_cfg[i].src);
        TB_EVENT: begin
          if (tb_cfg[i].ev_neigh) begin
            b_ev[i] = b_uf_q[(i + NB - 1) % NB];
          end else begin
            b_ev[i] = b_pin_ev[i];
          end
        end
        default: b_ev[i] = 1'b0;
      endcase
      b_st_d[i] = b_st_q[i];
      b_rel_d[i] = b_rel_q[i];
      b_cnt_d[i] = b_cnt_q[i];
      b_uf_d[i] = 1'b0;
      if (wr_b[i]) begin
        b_rel_d[i] = wdata;
        if (b_st_q[i] == ST_STOP) begin
          b_cnt_d[i] = wdata;
        end
      end
      case (b_st_q[i])
        ST_STOP: begin
          if (start_b[i] && b_counting[i]) begin
            b_st_d[i] = ST_RUN;
          end
        end
        ST_RUN: begin
          if (!start_b[i] || !b_counting[i]) begin
            b_st_d[i] = ST_STOP;
          end else if (b_ev[i]) begin
            if (b_cnt_q[i] == CNT_RST) begin
              // n+1 events per underflow: n down to zero inclusive
              b_cnt_d[i] = b_rel_q[i];
              b_uf_d[i] = 1'b1;
            end else begin
              b_cnt_d[i] = b_cnt_q[i] - CNT_ONE;
            end
          end
        end
        default: begin
          b_st_d[i] = ST_STOP;
        end
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (!nrst) begin
      for (int i = 0; i < NB; i++) begin
        b_st_q[i] <= ST_STOP;
        b_rel_q[i] <= CNT_RST;
        b_cnt_q[i] <= CNT_RST;
      end
      b_uf_q <= '0;
    end else begin
      b_st_q <= b_st_d;
      b_rel_q <= b_rel_d;
      b_cnt_q <= b_cnt_d;
      b_uf_q <= b_uf_d;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign pwm_ch2_output_pin = a_out_q[0];
  assign pwm_ch3_output_pin = a_out_q[1];
  assign irq_a = a_irq_q;
  assign irq_b = b_uf_q;
  assign tb_count = b_cnt_q;

  // the live modulator count is deliberately hidden
  always_comb begin
    for (int i = 0; i < NA; i++) begin
      pwm_rdata[i] = PWM_RD_VAL;
    end
  end

endmodule
`default_nettype wire

// ==== testbench/mft_sva.sv ====
`timescale 1ns/10ps
`default_nettype none
module mft_sva (
  input wire logic clock,
  input wire logic nrst,
  input wire logic [1:0] start_a,
  input wire logic [2:0] start_b,
  input wire logic [2:0] wr_b,
  input wire logic [2:0] counter_b_input_pin,
  input wire logic pwm_ch2_output_pin,
  input wire logic [1:0] irq_a,
  input wire logic [1:0][15:0] pwm_rdata,
  input wire logic [2:0] irq_b,
  input wire logic [2:0][15:0] tb_count,
  input wire logic [2:0] counter_b_pin_level
);
  import mft_pkg::*;
  // ----------------------------------------------------------------
  // reset history
  // ----------------------------------------------------------------
  // $past still sees pre-reset values for a few edges after release
  logic [2:0] rh_q;
  logic [2:0] rh_d;
  always_comb rh_d = {rh_q[1:0], nrst};
  always_ff @(posedge clock) rh_q <= rh_d;
  default clocking @(posedge clock); endclocking
  default disable iff (!nrst);
  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  rd_undef_a: assert property (pwm_rdata == {2{PWM_RD_VAL}})
    else $error("modulator read not fixed");
  irq_fall_a: assert property (irq_a[0] |-> $fell(pwm_ch2_output_pin))
    else $error("irq without fall");
  fall_irq_a: assert property (rh_q[0] && $fell(pwm_ch2_output_pin) && start_a[0]
    && $past(start_a[0]) |-> irq_a[0]) else $error("fall without irq");
  uflow_zero_a: assert property (irq_b[0] |-> $past(tb_count[0]) == 16'h0000
    || $past(tb_count[0], 2) == 16'h0000) else $error("irq not at underflow");
  stop_hold_a: assert property (rh_q[0] && !$past(start_b[0]) && !$past(start_b[0], 2)
    && !$past(wr_b[0]) |-> $stable(tb_count[0])) else $error("count moved stopped");
  step_a: assert property (rh_q[0] && $changed(tb_count[0]) && !$past(wr_b[0])
    |-> tb_count[0] == $past(tb_count[0]) - 16'h0001 || irq_b[0] || $past(irq_b[0]))
    else $error("bad count step");
  pin_lvl_a: assert property (&rh_q && $stable(counter_b_input_pin[0])
    && $past(counter_b_input_pin[0], 2) == counter_b_input_pin[0]
    && $past(counter_b_input_pin[0], 3) == counter_b_input_pin[0]
    |-> counter_b_pin_level[0] == counter_b_input_pin[0]) else $error("pin level");
  pwm_stop_a: assert property (&rh_q && !start_a[0] && !$past(start_a[0])
    && !$past(start_a[0], 2) |-> !pwm_ch2_output_pin) else $error("output while stopped");
  cover property (irq_a[0]);
  cover property (irq_b[1]);
  cover property (irq_b[2]);
endmodule
bind mft_top mft_sva u_mft_sva (.clock, .nrst, .start_a, .start_b, .wr_b,
  .counter_b_input_pin, .pwm_ch2_output_pin, .irq_a, .pwm_rdata, .irq_b, .tb_count,
  .counter_b_pin_level);
`default_nettype wire

// ==== testbench/mft_pulse_src.sv ====
`timescale 1ns/10ps
`default_nettype none
module mft_pulse_src #(
  parameter int N = 6
) (
  input wire logic clock,
  input wire logic fire,
  input wire logic [3:0] gap,
  output logic pin,
  output logic busy
);
  // ----------------------------------------------------------------
  // pulse train
  // ----------------------------------------------------------------
  // each level lasts gap cycles, so the pin sync never drops an edge
  initial begin
    pin = 1'b0;
    busy = 1'b0;
    forever begin
      @(posedge clock);
      if (fire) begin
        busy = 1'b1;
        repeat (2 * N) begin
          repeat (gap) @(posedge clock);
          #1 pin = ~pin;
        end
        busy = 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

// ==== testbench/tb_multifunction_timer_pwm_and_counter.sv ====
`timescale 1ns/10ps
`default_nettype none
module tb_multifunction_timer_pwm_and_counter;
  import mft_pkg::*;
  logic clock, nrst, gp, fire, pw2, pw3, sk;
  logic [3:0] gap;
  logic [15:0] wdata;
  logic [1:0] start_a, trig_a, wr_a, irq_a;
  logic [2:0] start_b, wr_b, irq_b, pin_lvl;
  logic [1:0][15:0] pwm_rdata;
  logic [2:0][15:0] tb_count;
  mft_pwm_cfg_t [1:0] pwm_cfg;
  mft_tb_cfg_t [2:0] tb_cfg;
  wire logic src_pin, src_busy;
  int fails, n_tests, na0, nb1, nb2, h, l;
  mft_top u_mft_top (.clock, .nrst, .subclk_pin(sk), .wdata, .start_a, .trig_a, .wr_a,
    .pwm_cfg, .start_b, .wr_b, .tb_cfg, .counter_b_input_pin({1'b0, src_pin, gp}),
    .pwm_ch2_output_pin(pw2), .pwm_ch3_output_pin(pw3), .irq_a, .pwm_rdata, .irq_b,
    .tb_count, .counter_b_pin_level(pin_lvl));
  mft_pulse_src u_mft_pulse_src (.clock, .fire, .gap, .pin(src_pin), .busy(src_busy));
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end
  // sub clock pin toggles every cycle, so one sub32 tick is 64 cycles
  always @(posedge clock) #1 sk = ~sk;
  // pulses are counted mid-cycle, away from the edge that launches them
  always @(negedge clock) begin
    na0 += int'(irq_a[0] === 1'b1);
    nb1 += int'(irq_b[1] === 1'b1);
    nb2 += int'(irq_b[2] === 1'b1);
  end
  task automatic stop_test();
    $display("fails=%0d n_tests=%0d", fails, n_tests);
    if (fails == 0 && n_tests > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input logic [15:0] g, e);
    n_tests++;
    if (g !== e) begin
      fails++;
      $display("unexpected at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic tick(input int k = 1);
    repeat (k) @(posedge clock);
    #1;
  endtask
  function automatic logic sig(input int s);
    case (s)
      0: sig = irq_b[0];
      1: sig = pw2;
      2: sig = !pw2;
      3: sig = pw3;
      4: sig = !pw3;
      default: sig = !src_busy;
    endcase
  endfunction
  // bounded wait; a hang ends the run as a mismatch
  task automatic wt(input int s, output int n);
    n = 0;
    while (sig(s) !== 1'b1) begin
      tick();
      n++;
      if (n > 70000) begin
        fails++;
        stop_test();
      end
    end
  endtask
  task automatic wr(input bit b, input int i, input logic [15:0] v);
    if (b)
      wr_b[i] = 1'b1;
    else
      wr_a[i] = 1'b1;
    wdata = v;
    tick();
    wr_a = '0;
    wr_b = '0;
  endtask
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_timer();
    tb_cfg[0] = {TB_TIMER, SRC_DIV1, EDGE_RISE, 1'b0};
    wr(1, 0, 16'h0003);
    chk(tb_count[0], 16'h0003);
    gp = 1'b1;
    start_b[0] = 1'b1;
    wt(0, h);
    tick();
    wt(0, h);
    chk(16'(h + 1), 16'h0004);
    wr(1, 0, 16'h0007);
    chk(16'(tb_count[0] < 16'h0004), 16'h0001);
    wt(0, h);
    tick();
    wt(0, h);
    chk(16'(h + 1), 16'h0008);
    chk({15'h0000, pin_lvl[0]}, 16'h0001);
    start_b[0] = 1'b0;
    tick(2);
    h = tb_count[0];
    tick(5);
    chk(tb_count[0], 16'(h));
    tb_cfg[0] = {TB_TIMER, SRC_SUB32, EDGE_RISE, 1'b0};
    wr(1, 0, 16'h0000);
    start_b[0] = 1'b1;
    wt(0, h);
    tick();
    wt(0, h);
    chk(16'(h + 1), 16'h0040);
    start_b[0] = 1'b0;
    tick(2);
  endtask
  task automatic t_event();
    for (int i = 0; i < 3; i++) begin
      tb_cfg[1] = {TB_EVENT, SRC_DIV1, 2'(i), 1'b0};
      tb_cfg[2] = {TB_EVENT, SRC_DIV1, EDGE_RISE, 1'b1};
      wr(1, 1, 16'h0002);
      tick();
      wr(1, 2, 16'h0000);
      start_b = 3'b110;
      tick();
      nb1 = 0;
      nb2 = 0;
      gap = 4'(2 + 4 * i);
      fire = 1'b1;
      tick();
      fire = 1'b0;
      wt(5, h);
      tick(10);
      chk(16'(nb1), 2'(i) == EDGE_BOTH ? 16'h0004 : 16'h0002);
      chk(16'(nb2), 16'(nb1));
      start_b = 3'b000;
      tick();
    end
  endtask
  task automatic t_pwm16();
    pwm_cfg[0] = {SRC_DIV1, 1'b0, 1'b0};
    wr(0, 0, 16'h0003);
    na0 = 0;
    start_a[0] = 1'b1;
    wt(1, h);
    wt(2, h);
    chk(16'(h), 16'h0003);
    // gating is armed now, yet a running channel must still ignore it
    pwm_cfg[0].trig_en = 1'b1;
    trig_a[0] = 1'b1;
    wr(0, 0, 16'h0005);
    trig_a[0] = 1'b0;
    wt(1, l);
    chk(16'(h + l + 1), 16'hFFFF);
    wt(2, h);
    chk(16'(h), 16'h0005);
    start_a[0] = 1'b0;
    tick(3);
    chk(16'(na0), 16'h0002);
  endtask
  task automatic t_pwm8();
    pwm_cfg[1] = {SRC_DIV8, 1'b1, 1'b1};
    wr(0, 1, 16'h0201);
    start_a[1] = 1'b1;
    tick(40);
    chk({15'h0000, pw3}, 16'h0000);
    trig_a[1] = 1'b1;
    tick();
    trig_a[1] = 1'b0;
    wt(3, h);
    wt(4, h);
    // the first high is cut by the free-running prescaler phase
    wt(3, l);
    wt(4, h);
    chk(16'(h), 16'h0020);
    wt(3, l);
    chk(16'(h + l), 16'h0FF0);
    start_a[1] = 1'b0;
  endtask
  initial begin
    {nrst, gp, fire, wdata, start_a, trig_a, wr_a, start_b, wr_b} = '0;
    pwm_cfg = '0;
    tb_cfg = '0;
    gap = 4'h2;
    sk = 1'b0;
    tick(3);
    nrst = 1'b1;
    chk({pw2, pw3, irq_a, irq_b, tb_count[0][8:0]}, 16'h0000);
    t_timer();
    t_event();
    t_pwm16();
    t_pwm8();
    stop_test();
  end
endmodule
`default_nettype wire
